// ---- hdl/sas_pkg.sv ----
// constants shared by the converter sequencer files
// assumes a 200 MHz system clock and a plain strobe register port
package sas_pkg;
    // register offsets (16-bit registers, one per address)
    localparam logic [3:0] REG_CTRL_ONE    = 4'h0;
    localparam logic [3:0] REG_CTRL_TWO    = 4'h1;
    localparam logic [3:0] REG_CTRL_THREE  = 4'h2;
    localparam logic [3:0] REG_SCAN_LOW    = 4'h3;
    localparam logic [3:0] REG_PIN_CFG     = 4'h4;
    localparam logic [3:0] REG_STATUS      = 4'h5;
    localparam logic [3:0] REG_RESULT_BASE = 4'h8;
    // control one field positions
    localparam int BIT_ON       = 15;
    localparam int BIT_IDLE     = 13;
    localparam int BIT_RES      = 10;
    localparam int BIT_FORM     = 8;
    localparam int BIT_TRIG     = 5;
    localparam int BIT_SIM      = 3;
    localparam int BIT_AUTO     = 2;
    localparam int BIT_SAMPLE_ACTIVE     = 1;
    localparam int BIT_DONE     = 0;
    // control two field positions
    localparam int BIT_SCAN     = 10;
    localparam int BIT_CHPS     = 8;
    localparam int BIT_SMPI     = 2;
    // control three field positions
    localparam int BIT_RC       = 15;
    localparam int BIT_SAMC     = 8;
    // write masks: implemented bits only
    localparam logic [15:0] MASK_CTRL_ONE   = 16'hA7EF;
    localparam logic [15:0] MASK_CTRL_TWO   = 16'h073C;
    localparam logic [15:0] MASK_CTRL_THREE = 16'h9FFF;
    localparam logic [15:0] RESET_VALUE     = 16'h0000;
    // trigger codes
    localparam logic [2:0] TRIG_SOFT  = 3'h0;
    localparam logic [2:0] TRIG_PIN   = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_PWM1  = 3'h3;
    localparam logic [2:0] TRIG_PWM2  = 3'h5;
    localparam logic [2:0] TRIG_AUTO  = 3'h7;
    // number of analog inputs and result slots
    localparam int NUM_INPUTS = 9;
    localparam int NUM_SLOTS  = 16;
    // conversion length in conversion clock periods
    localparam logic [3:0] CONV_TAD_10 = 4'hC;
    localparam logic [3:0] CONV_TAD_12 = 4'hE;
    // internal rc period as system cycles
    localparam int RC_PERIOD_NS = 250;
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [7:0] RC_DIV = 8'((RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
    typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_CONVERT, ST_HOLD} sas_state_type;
endpackage

// ---- hdl/sas_format.sv ----
// result formatting for the converter sequencer
// pure combinational, raw result right aligned in 12 bits
`timescale 1ns/1ps
module sas_format (
    input  wire logic        twelve,
    input  wire logic [1:0]  form,
    input  wire logic [11:0] raw,
    output logic [15:0]      dout
);
    logic [9:0]  d10;
    logic        s10;
    logic        s12;
    assign d10 = raw[9:0];
    assign s10 = ~raw[9];
    assign s12 = ~raw[11];
    // four forms per resolution, sign is inverted msb
    always_comb begin
        dout = 16'h0000;
        if (twelve) begin
            case (form)
                2'b00: dout = {4'h0, raw};
                2'b01: dout = {{5{s12}}, raw[10:0]};
                2'b10: dout = {raw, 4'h0};
                default: dout = {s12, raw[10:0], 4'h0};
            endcase
        end else begin
            case (form)
                2'b00: dout = {6'h00, d10};
                2'b01: dout = {{7{s10}}, d10[8:0]};
                2'b10: dout = {d10, 6'h00};
                default: dout = {s10, d10[8:0], 6'h00};
            endcase
        end
    end
endmodule

// ---- hdl/sas_sequencer.sv ----
// sample and convert sequencer for a successive approximation converter
// assumes the analog front end returns a 12-bit result at the end of conversion
// and that trigger inputs are single pulses from other clock domains or pins
`timescale 1ns/1ps
module sas_sequencer
    import sas_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [15:0]      RDATA,
    input  wire logic        IDLE_MODE,
    input  wire logic        TRIG_PIN_IN,
    input  wire logic        TRIG_TIMER_IN,
    input  wire logic        TRIG_PWM1_IN,
    input  wire logic        TRIG_PWM2_IN,
    input  wire logic [11:0] CONV_RESULT,
    input  wire logic [8:0]  OTHER_PIN_CFG,
    output logic             SAMPLING,
    output logic [1:0]       HOLD_CHANNEL,
    output logic [3:0]       INPUT_SELECT,
    output logic             CONVERT_START,
    output logic             IRQ_FLAG,
    output logic [8:0]       DIGITAL_ENABLE
);
    import sas_pkg::*;
    // ==========================================
    // registers
    logic [15:0] ctrl_one, ctrl_two, ctrl_three, scan_list, pin_cfg;
    logic [15:0] slot [NUM_SLOTS];
    logic [3:0]  wr_ptr;
    logic [3:0]  seq_count;
    logic [3:0]  scan_idx;
    logic [1:0]  chan;
    logic [7:0]  div_cnt;
    logic        conversion_clock_period;
    logic [4:0]  sample_active_cnt;
    logic [3:0]  conv_cnt;
    logic [15:0] formatted;
    sas_state_type state;
    logic        twelve, running, trig_hit, conv_end, set_done, set_irq;
    logic [1:0]  last_chan;
    logic [2:0]  p0, p1, p2, p3;
    logic        e0, e1, e2, e3;

    assign twelve  = ctrl_one[BIT_RES];
    // off bit stops the sequencer but not the conversion clock divider, idle halt returns to off and resets the sequence in idle
    assign running = ctrl_one[BIT_ON] && !(ctrl_one[BIT_IDLE] && IDLE_MODE);
    // channels per sequence; count field ignored in 12-bit
    assign last_chan = twelve ? 2'd0 : (ctrl_two[BIT_CHPS+1] ? 2'd3 :
                       (ctrl_two[BIT_CHPS] ? 2'd1 : 2'd0));

    // ==========================================
    // trigger synchronisers, a rise counts when stage two is high and stage three still low
    function automatic logic rise(input logic [2:0] p);
        rise = p[1] & ~p[2];
    endfunction
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            p0 <= 3'h0; p1 <= 3'h0; p2 <= 3'h0; p3 <= 3'h0;
        end else begin
            p0 <= {p0[1:0], TRIG_PIN_IN};
            p1 <= {p1[1:0], TRIG_TIMER_IN};
            p2 <= {p2[1:0], TRIG_PWM1_IN};
            p3 <= {p3[1:0], TRIG_PWM2_IN};
        end
    end
    assign e0 = rise(p0);
    assign e1 = rise(p1);
    assign e2 = rise(p2);
    assign e3 = rise(p3);

    // ==========================================
    // conversion clock enable: divider or fixed rc rate
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_cnt <= 8'h00;
            conversion_clock_period <= 1'b0;
        end else if (div_cnt >= (ctrl_three[BIT_RC] ? RC_DIV : ctrl_three[7:0])) begin
            div_cnt <= 8'h00;
            conversion_clock_period <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            conversion_clock_period <= 1'b0;
        end
    end

    // trigger source decode, reserved codes never fire
    always_comb begin
        case (ctrl_one[BIT_TRIG+:3])
            TRIG_PIN:   trig_hit = e0;
            TRIG_TIMER: trig_hit = e1;
            TRIG_PWM1:  trig_hit = e2;
            TRIG_PWM2:  trig_hit = e3;
            TRIG_AUTO:  trig_hit = conversion_clock_period && sample_active_cnt >= ctrl_three[BIT_SAMC+:5];
            default:    trig_hit = 1'b0;
        endcase
    end

    assign conv_end = state == ST_CONVERT && conversion_clock_period &&
                      conv_cnt == (twelve ? CONV_TAD_12 : CONV_TAD_10);
    // done set at the end of every channel's conversion
    assign set_done = conv_end;
    // flag on the (n+1)th sequence, same cycle as done
    assign set_irq  = conv_end && chan == last_chan &&
                      seq_count == ctrl_two[BIT_SMPI+:4];

    // ==========================================
    // sequencer state machine
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_OFF;
            sample_active_cnt <= 5'h00;
            conv_cnt <= 4'h0;
            chan <= 2'd0;
        end else if (!running) begin
            state <= ST_OFF;
            chan <= 2'd0;
        end else begin
            case (state)
                ST_OFF: state <= ST_HOLD;
                ST_HOLD: begin
                    sample_active_cnt <= 5'h00;
                    if (ctrl_one[BIT_SAMPLE_ACTIVE]) state <= ST_SAMPLE;
                end
                ST_SAMPLE: begin
                    if (conversion_clock_period && sample_active_cnt != 5'h1F) sample_active_cnt <= sample_active_cnt + 5'h01;
                    // software clear or selected trigger ends sampling
                    if (!ctrl_one[BIT_SAMPLE_ACTIVE] || trig_hit) begin
                        state <= ST_CONVERT;
                        conv_cnt <= 4'h0;
                    end
                end
                default: begin
                    if (conversion_clock_period) conv_cnt <= conv_cnt + 4'h1;
                    if (conv_end) begin
                        // sequential channels convert one after another
                        if (chan != last_chan) begin
                            chan <= chan + 2'd1;
                            conv_cnt <= 4'h0;
                        end else begin
                            chan <= 2'd0;
                            state <= ST_HOLD;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================
    // sequence counter, scan index and write pointer
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            seq_count <= 4'h0;
            wr_ptr <= 4'h0;
            scan_idx <= 4'h0;
        end else if (!running) begin
            seq_count <= 4'h0;
            wr_ptr <= 4'h0;
            scan_idx <= 4'h0;
        end else if (conv_end) begin
            if (set_irq) begin
                seq_count <= 4'h0;
                wr_ptr <= 4'h0;
                scan_idx <= 4'h0;
            end else begin
                wr_ptr <= wr_ptr + 4'h1;
                if (chan == last_chan) begin
                    seq_count <= seq_count + 4'h1;
                    if (ctrl_two[BIT_SCAN]) scan_idx <= scan_idx + 4'h1;
                end
            end
        end
    end

    // input number for the current channel: scan list or channel index
    function automatic logic [3:0] scan_pick(input logic [15:0] list, input logic [3:0] idx);
        logic [3:0] k;
        logic [3:0] found;
        found = 4'h0;
        k = 4'h0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (list[i]) begin
                if (k == idx) found = 4'(i);
                k = k + 4'h1;
            end
        end
        scan_pick = found;
    endfunction

    sas_format u_format (
        .twelve (twelve),
        .form   (ctrl_one[BIT_FORM+:2]),
        .raw    (CONV_RESULT),
        .dout   (formatted)
    );

    // result slots, index from pointer only
    always_ff @(posedge CLK) begin
        if (conv_end) slot[wr_ptr] <= formatted;
    end

    // ==========================================
    // register writes and hardware flags
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_one <= RESET_VALUE;
            ctrl_two <= RESET_VALUE;
            ctrl_three <= RESET_VALUE;
            scan_list <= RESET_VALUE;
            pin_cfg <= RESET_VALUE;
            IRQ_FLAG <= 1'b0;
        end else begin
            if (WR && ADDR == REG_CTRL_ONE) begin
                // done is clear only; hardware bits merged below
                ctrl_one <= (WDATA & MASK_CTRL_ONE & ~16'h0001) |
                            (ctrl_one & 16'h0001 & WDATA);
                // resolution held while on, so software must switch off first
                if (ctrl_one[BIT_ON]) ctrl_one[BIT_RES] <= ctrl_one[BIT_RES];
                // simultaneous bit not implemented in 12-bit
                // use the resolution that will stand, since a held bit can differ from WDATA
                if (ctrl_one[BIT_ON] ? ctrl_one[BIT_RES] : WDATA[BIT_RES])
                    ctrl_one[BIT_SIM] <= 1'b0;
            end else if (WR && ADDR == REG_CTRL_TWO) begin
                ctrl_two <= WDATA & MASK_CTRL_TWO;
            end else if (WR && ADDR == REG_CTRL_THREE) begin
                ctrl_three <= WDATA & MASK_CTRL_THREE;
            end else if (WR && ADDR == REG_SCAN_LOW) begin
                scan_list <= {7'h00, WDATA[8:0]};
            end else if (WR && ADDR == REG_PIN_CFG) begin
                pin_cfg <= {7'h00, WDATA[8:0]};
            end
            // done cleared at conversion start, set at end; set wins
            if (state == ST_SAMPLE && running && (!ctrl_one[BIT_SAMPLE_ACTIVE] || trig_hit))
                ctrl_one[BIT_DONE] <= 1'b0;
            if (set_done) ctrl_one[BIT_DONE] <= 1'b1;
            // hardware clears sample on trigger, auto sample re-arms
            if (state == ST_SAMPLE && running && trig_hit && ctrl_one[BIT_TRIG+:3] != TRIG_SOFT)
                ctrl_one[BIT_SAMPLE_ACTIVE] <= 1'b0;
            if (state == ST_HOLD && ctrl_one[BIT_AUTO] && running)
                ctrl_one[BIT_SAMPLE_ACTIVE] <= 1'b1;
            // interrupt flag clear via status write, set wins
            if (WR && ADDR == REG_STATUS && WDATA[0]) IRQ_FLAG <= 1'b0;
            if (set_irq) IRQ_FLAG <= 1'b1;
        end
    end

    // ==========================================
    // outputs to the analog front end, all registered
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SAMPLING <= 1'b0;
            HOLD_CHANNEL <= 2'd0;
            INPUT_SELECT <= 4'h0;
            CONVERT_START <= 1'b0;
            DIGITAL_ENABLE <= 9'h000;
        end else begin
            SAMPLING <= state == ST_SAMPLE;
            // simultaneous mode converts channels held together
            HOLD_CHANNEL <= (ctrl_one[BIT_SIM] && !twelve) ? last_chan : chan;
            INPUT_SELECT <= ctrl_two[BIT_SCAN] ? scan_pick(scan_list, scan_idx)
                                               : {2'b00, chan};
            CONVERT_START <= state == ST_SAMPLE && running &&
                             (!ctrl_one[BIT_SAMPLE_ACTIVE] || trig_hit);
            // digital only when both converters release the pin
            DIGITAL_ENABLE <= pin_cfg[8:0] & OTHER_PIN_CFG;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 16'h0000;
        end else if (!RD) begin
            RDATA <= 16'h0000;
        end else if (ADDR == REG_CTRL_ONE) begin
            RDATA <= ctrl_one;
        end else if (ADDR == REG_CTRL_TWO) begin
            RDATA <= twelve ? (ctrl_two & ~16'h0300) : ctrl_two;
        end else if (ADDR == REG_CTRL_THREE) begin
            RDATA <= ctrl_three;
        end else if (ADDR == REG_SCAN_LOW) begin
            RDATA <= scan_list;
        end else if (ADDR == REG_PIN_CFG) begin
            RDATA <= pin_cfg;
        end else if (ADDR == REG_STATUS) begin
            RDATA <= {11'h000, wr_ptr, IRQ_FLAG};
        end else if (ADDR >= REG_RESULT_BASE) begin
            RDATA <= slot[{1'b0, ADDR[2:0]} + (wr_ptr & 4'h8)];
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ==========================================
    // checks
    done_rises_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        conv_end |=> ctrl_one[BIT_DONE]) else $error("done not set at conversion end");
    irq_with_done_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        $rose(IRQ_FLAG) |-> $rose(ctrl_one[BIT_DONE]) || ctrl_one[BIT_DONE])
        else $error("irq flag without done");
    off_stops_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        !ctrl_one[BIT_ON] |=> state == ST_OFF) else $error("running while off");
    idle_halt_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        ctrl_one[BIT_IDLE] && IDLE_MODE |=> !SAMPLING || !running)
        else $error("running in idle");
    sim_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        twelve |-> !ctrl_one[BIT_SIM] || $past(WR)) else $error("simultaneous bit in 12-bit");
    ptr_wrap_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        set_irq |=> wr_ptr == 4'h0) else $error("pointer not wrapped");
    seq_bound_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        seq_count <= ctrl_two[BIT_SMPI+:4] || $past(WR)) else $error("sequence count overrun");
    dig_en_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        ##1 DIGITAL_ENABLE == ($past(pin_cfg[8:0]) & $past(OTHER_PIN_CFG)))
        else $error("digital enable mismatch");
endmodule

// ---- test/sas_front_model.sv ----
// partner model: analog front end and the trigger sources
// assumes it shares the system clock and reset with the sequencer
`timescale 1ns/1ps
module sas_front_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        convert_start,
    input  wire logic        sampling,
    input  wire logic [11:0] next_raw,
    input  wire logic [3:0]  fire,
    output logic [11:0]      conv_result,
    output logic [3:0]       trig
);
    // ==========
    // front end
    logic [11:0] held;
    logic        busy;
    logic [2:0]  cnt;

    // value held from start until sampling resumes, then inverted so stale data shows
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held <= 12'h000;
            busy <= 1'b0;
        end else if (convert_start) begin
            held <= next_raw;
            busy <= 1'b1;
        end else if (sampling) begin
            busy <= 1'b0;
        end
    end
    assign conv_result = busy ? held : ~held;

    // stretch a request to a 5-cycle level, long enough for the synchroniser
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig <= 4'h0;
            cnt <= 3'h0;
        end else if (|fire) begin
            trig <= fire;
            cnt <= 3'h4;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end else begin
            trig <= 4'h0;
        end
    end
endmodule

// ---- test/sas_sequencer_tb.sv ----
// self-checking bench for the converter sequencer
// assumes sas_pkg, sas_sequencer and sas_front_model are compiled first
`timescale 1ns/1ps
module sas_sequencer_tb;
    import sas_pkg::*;
    typedef struct {logic [15:0] e; logic [15:0] m;} sas_exp_type;
    // ==========
    // signals
    logic        CLK = 1'b0;
    logic        ARST_N = 1'b0;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        IDLE_MODE = 1'b0;
    logic [8:0]  OTHER_PIN_CFG = 9'h000;
    logic [11:0] next_raw = 12'h000;
    logic [3:0]  fire = 4'h0;
    logic [15:0] RDATA;
    logic [11:0] CONV_RESULT;
    logic [3:0]  trig;
    logic [8:0]  DIGITAL_ENABLE;
    logic        SAMPLING, CONVERT_START, IRQ_FLAG;
    logic [1:0]  HOLD_CHANNEL;
    logic [3:0]  INPUT_SELECT;
    logic [3:0]  hold_seen = 4'h0;
    logic [3:0]  sel_seen [4];
    int          m;
    logic        rd_d = 1'b0;
    logic [11:0] r;
    logic [15:0] msk [5] = '{16'h0000, MASK_CTRL_TWO, MASK_CTRL_THREE, 16'h01FF, 16'h01FF};
    logic [2:0]  codes [4] = '{TRIG_PIN, TRIG_TIMER, TRIG_PWM1, TRIG_PWM2};
    sas_exp_type exp_q[$];
    sas_exp_type x;
    int          fails = 0;
    int          num_checks = 0;
    int          n_starts = 0;
    int          n;

    always #2.5 CLK = ~CLK;

    sas_sequencer u_dut (
        .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IDLE_MODE(IDLE_MODE), .TRIG_PIN_IN(trig[0]),
        .TRIG_TIMER_IN(trig[1]), .TRIG_PWM1_IN(trig[2]), .TRIG_PWM2_IN(trig[3]),
        .CONV_RESULT(CONV_RESULT), .OTHER_PIN_CFG(OTHER_PIN_CFG), .SAMPLING(SAMPLING),
        .HOLD_CHANNEL(HOLD_CHANNEL), .INPUT_SELECT(INPUT_SELECT),
        .CONVERT_START(CONVERT_START),
        .IRQ_FLAG(IRQ_FLAG), .DIGITAL_ENABLE(DIGITAL_ENABLE));
    sas_front_model u_front (
        .clk(CLK), .arst_n(ARST_N), .convert_start(CONVERT_START), .sampling(SAMPLING),
        .next_raw(next_raw), .fire(fire), .conv_result(CONV_RESULT), .trig(trig));

    // ==========
    // checking and bus tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a gap cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back('{e, m});
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic wait_irq();
        int i;
        for (i = 0; i < 2000 && IRQ_FLAG !== 1'b1; i++) @(posedge CLK);
        if (i == 2000) begin
            fails++;
            $display("unexpected irq timeout expected %h seen %h", 1'b1, IRQ_FLAG);
            stop_test();
        end
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge CLK) begin
        rd_d <= RD;
        if (rd_d && exp_q.size() > 0) begin
            x = exp_q.pop_front();
            chk("read data", x.e & x.m, RDATA & x.m);
        end
    end

    // count starts; each one steps the value the front end returns next
    always @(posedge CLK) begin
        hold_seen[HOLD_CHANNEL] <= 1'b1;
        if (CONVERT_START === 1'b1) begin
            sel_seen[2'(n_starts)] <= INPUT_SELECT;
            n_starts++;
            next_raw <= next_raw + 12'h001;
        end
    end

    // expected result word; 10-bit data sits in r[9:0]
    function automatic logic [15:0] fmt(input logic [11:0] r, input logic t,
                                        input logic [1:0] f);
        logic [11:0] d;
        d = t ? r : {r[9:0], 2'b00};
        case (f)
            2'b00: fmt = t ? {4'h0, r} : {6'h00, r[9:0]};
            2'b01: fmt = t ? {{5{~r[11]}}, r[10:0]} : {{7{~r[9]}}, r[8:0]};
            2'b10: fmt = {d, 4'h0};
            default: fmt = {~d[11], d[10:0], 4'h0};
        endcase
    endfunction

    // one sequence: configure off, turn on, sample, trigger, check slot 0 and done
    task automatic seq(input logic [15:0] c, input logic [3:0] f, input logic [15:0] e);
        wr(REG_CTRL_ONE, c & 16'h7FFF);
        wr(REG_CTRL_ONE, c);
        wr(REG_STATUS, 16'h0001);
        @(posedge CLK);
        chk("irq flag", 16'h0000, {15'h0000, IRQ_FLAG});
        wr(REG_CTRL_ONE, c | 16'h0002);
        if (f == 4'h0) begin
            wr(REG_CTRL_ONE, c);
        end else begin
            fire <= ~f;
            @(posedge CLK);
            fire <= 4'h0;
            repeat (30) @(posedge CLK);
            chk("sampling", 16'h0001, {15'h0000, SAMPLING});
            fire <= f;
            @(posedge CLK);
            fire <= 4'h0;
        end
        wait_irq();
        @(posedge CLK);
        chk("sampling", 16'h0000, {15'h0000, SAMPLING});
        rd(REG_RESULT_BASE, e, 16'hFFFF);
        rd(REG_CTRL_ONE, 16'h0001, 16'h0001);
        wr(REG_CTRL_ONE, 16'h0000);
    endtask

    // ==========
    // main sequence
    initial begin
        n = $urandom(32060);
        OTHER_PIN_CFG <= 9'($urandom);
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        for (n = 0; n < 8; n++) rd(4'(n), 16'h0000, 16'hFFFF);
        wr(REG_CTRL_ONE, 16'h0708);
        rd(REG_CTRL_ONE, 16'h0700, 16'hFFFF);
        wr(REG_CTRL_ONE, 16'h0002);
        @(posedge CLK);
        chk("sampling", 16'h0000, {15'h0000, SAMPLING});
        wr(REG_CTRL_ONE, 16'h8000);
        wr(REG_CTRL_ONE, 16'h8400);
        rd(REG_CTRL_ONE, 16'h8000, 16'hFFFF);
        wr(REG_CTRL_ONE, 16'h0000);
        for (n = 1; n < 5; n++) begin
            wr(4'(n), 16'hFFFF);
            rd(4'(n), msk[n], 16'hFFFF);
            wr(4'(n), 16'h0000);
        end
        wr(REG_PIN_CFG, 16'h01A5);
        repeat (2) @(posedge CLK);
        chk("digital enable", {7'h00, 9'h1A5 & OTHER_PIN_CFG}, {7'h00, DIGITAL_ENABLE});
        // every format in both resolutions; idle without halt keeps running
        for (n = 0; n < 8; n++) begin
            wr(REG_CTRL_THREE, 16'(n % 4));
            r = 12'($urandom) & (n > 3 ? 12'hFFF : 12'h3FF);
            next_raw <= r;
            IDLE_MODE <= (n > 3);
            seq(16'h8000 | 16'((n / 4) << 10) | 16'((n % 4) << 8), 4'h0,
                fmt(r, n > 3, 2'(n)));
        end
        IDLE_MODE <= 1'b0;
        // each hardware trigger, on the internal clock, after the others are ignored
        wr(REG_CTRL_THREE, 16'h8000);
        for (n = 0; n < 4; n++) begin
            r = 12'($urandom) & 12'h3FF;
            next_raw <= r;
            seq(16'h8000 | {8'h00, codes[n], 5'h00}, 4'(1 << n), {6'h00, r[9:0]});
        end
        // idle halt stops conversion
        IDLE_MODE <= 1'b1;
        wr(REG_CTRL_ONE, 16'h2000);
        wr(REG_CTRL_ONE, 16'hA000);
        wr(REG_CTRL_ONE, 16'hA002);
        n = n_starts;
        wr(REG_CTRL_ONE, 16'hA000);
        repeat (60) @(posedge CLK);
        chk("conversion starts", 16'(n), 16'(n_starts));
        IDLE_MODE <= 1'b0;
        wr(REG_CTRL_ONE, 16'h0000);
        // auto sample and auto convert, irq after three sequences
        wr(REG_CTRL_TWO, 16'h0008);
        wr(REG_CTRL_THREE, 16'h1F00);
        next_raw <= 12'h100;
        n = n_starts;
        wr(REG_STATUS, 16'h0001);
        wr(REG_CTRL_ONE, 16'h00E4);
        wr(REG_CTRL_ONE, 16'h80E6);
        wait_irq();
        wr(REG_CTRL_ONE, 16'h0000);
        chk("sequences per irq", 16'h0003, 16'(n_starts - n));
        for (n = 0; n < 3; n++) rd(REG_RESULT_BASE + 4'(n), 16'h0100 + 16'(n), 16'hFFFF);
        rd(REG_STATUS, 16'h0001, 16'h001F);
        // scan two inputs, two channels one after another, irq after two sequences
        wr(REG_SCAN_LOW, 16'h0014);
        wr(REG_CTRL_TWO, 16'h0504);
        next_raw <= 12'h200;
        m = n_starts;
        wr(REG_STATUS, 16'h0001);
        wr(REG_CTRL_ONE, 16'h00E4);
        wr(REG_CTRL_ONE, 16'h80E6);
        wait_irq();
        wr(REG_CTRL_ONE, 16'h0000);
        chk("scan sequences", 16'h0002, 16'(n_starts - m));
        chk("scan input one", 16'h0002, {12'h000, sel_seen[2'(m)]});
        chk("scan input two", 16'h0004, {12'h000, sel_seen[2'(m + 1)]});
        chk("hold channels", 16'h0003, {12'h000, hold_seen});
        for (n = 0; n < 4; n++) rd(REG_RESULT_BASE + 4'(n), 16'h0200 + 16'(n / 2), 16'hFFFF);
        repeat (2) @(posedge CLK);
        if (exp_q.size() != 0) begin
            fails++;
            $display("unexpected pending reads expected %0d seen %0d", 0, exp_q.size());
        end
        stop_test();
    end
endmodule
